// [debug_link_pkg.sv]
// Constants and types shared by both ends of the debug link
// Summary of operation
// - Three 64-bit unlock keys, low byte first
// - Valid key sets its key-active status bit
// - Debugger erases: key, reset pulse, poll lock
// - Locked: only register space, no system bus
// - Erase forces brownout detector on, fuse level
// - Memory controller writes only when unlocked
// - Programming: key, reset pulse, poll status
// - Programming ends with another reset pulse
// - Signature asserts system reset until cleared
// - User row: key, reset pulse, poll status
// - User row writes only first 32 bytes
// - Buffered bytes copied one-to-one to row
// - Finish row: final bit, poll, clear key
// - User row mode refuses memory reads
// - Event on every sync rising edge, always
// - Link works in sleep; bus blocked clockless
// - Sleeping bit set in idle or deeper
// - Clock request default one keeps clock
// - Registers reachable from the link only
// - Low offsets phy, upper offsets access layer
// - Signature 0x59 resets, other values clear
// - Programming key clears when sequence ends
package debug_link_pkg;
  localparam logic [63:0] KEY_ERASE      = 64'h4E564D4572617365;
  localparam logic [63:0] KEY_PROGRAM    = 64'h4E564D50726F6720;
  localparam logic [63:0] KEY_USER_ROW   = 64'h4E564D5573267465;
  localparam logic [3:0]  KEY_BYTES      = 4'h8;
  localparam logic [7:0]  RESET_SIGNATURE = 8'h59;

  localparam logic [3:0] OFS_REVISION   = 4'h0;
  localparam logic [3:0] OFS_ERROR      = 4'h1;
  localparam logic [3:0] OFS_PHY_FIRST  = 4'h2;
  localparam logic [3:0] OFS_PHY_SECOND = 4'h3;
  localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
  localparam logic [3:0] OFS_RESET_REQ  = 4'h8;
  localparam logic [3:0] OFS_ACC_CTRL   = 4'h9;
  localparam logic [3:0] OFS_SYS_CTRL   = 4'hA;
  localparam logic [3:0] OFS_SYS_STATUS = 4'hB;
  localparam logic [3:0] OFS_SCAN       = 4'hC;

  localparam int BIT_USER_ROW_KEY = 5;
  localparam int BIT_PROGRAM_KEY  = 4;
  localparam int BIT_ERASE_KEY    = 3;
  localparam int BIT_KEEP_CLOCK   = 0;
  localparam int BIT_FINAL_WRITE  = 1;
  localparam int BIT_RST_ACTIVE   = 5;
  localparam int BIT_SLEEPING     = 4;
  localparam int BIT_PROG_STATUS  = 3;
  localparam int BIT_UROW_STATUS  = 2;
  localparam int BIT_LOCK         = 0;

  localparam logic [3:0] REVISION_VALUE   = 4'h1; // Arbitrary revision code
  localparam logic [7:0] ACC_CTRL_RESET   = 8'h02;
  localparam logic [7:0] SYS_CTRL_RESET   = 8'h01;
  localparam int         USER_ROW_BYTES   = 32;
  localparam int         LINK_HALF_CYCLES = 4;   // 25 MHz / 8 = 320 ns link

  typedef enum logic [2:0] {
    CMD_IDLE      = 3'h0,
    CMD_KEY_BYTE  = 3'h1,
    CMD_REG_WRITE = 3'h2,
    CMD_REG_READ  = 3'h3,
    CMD_MEM_WRITE = 3'h4,
    CMD_MEM_READ  = 3'h5,
    CMD_SYNC      = 3'h6
  } link_cmd_e;
endpackage : debug_link_pkg

// [debug_link_if.sv]
// Link between debugger end and device end
interface debug_link_if;
  import debug_link_pkg::*;
  logic              link_clk;
  logic [2:0]        link_cmd;
  logic [15:0]       link_addr;
  logic [7:0]        link_wdata;
  logic              link_sync;
  logic [7:0]        link_rdata;
  logic              link_ok;
  logic              link_ack;
  modport device (input link_clk, link_cmd, link_addr, link_wdata,
                  link_sync, output link_rdata, link_ok, link_ack);
  modport host (output link_clk, link_cmd, link_addr, link_wdata,
                link_sync, input link_rdata, link_ok, link_ack);
endinterface : debug_link_if

// [debug_access_device.sv]
// Device end: key unlock, reset request, access gating, sync events
module debug_access_device
  import debug_link_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  debug_link_if.device     link,
  input  wire logic        lock_bits,
  input  wire logic        sys_sleeping,
  input  wire logic        erase_done,
  input  wire logic [2:0]  bod_fuse_level,
  input  wire logic [2:0]  scan_status,
  input  wire logic [7:0]  mem_rdata,
  output logic             system_reset_active,
  output logic             erase_request,
  output logic             brownout_force,
  output logic [2:0]       brownout_level,
  output logic             cpu_hold,
  output logic             mem_we,
  output logic             mem_re,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             row_we,
  output logic [4:0]       row_addr,
  output logic [7:0]       row_wdata,
  output logic             sync_edge_event,
  output logic             keep_clock_request
);
  // Two-stage capture of every link input; only stage two is read
  logic [28:0] meta_q, sync_q;
  logic        clk_prev_q, sync_prev_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q      <= '0;
      sync_q      <= '0;
      clk_prev_q  <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      meta_q      <= {link.link_clk, link.link_sync, link.link_cmd,
                      link.link_addr, link.link_wdata};
      sync_q      <= meta_q;
      clk_prev_q  <= sync_q[28];
      sync_prev_q <= sync_q[27];
    end
  end
  logic        edge_seen;
  logic [2:0]  cmd;
  logic [15:0] addr;
  logic [7:0]  wdata;
  assign edge_seen = sync_q[28] && !clk_prev_q;
  assign cmd       = sync_q[26:24];
  assign addr      = sync_q[23:8];
  assign wdata     = sync_q[7:0];

  // Sync edge event cannot be masked
  always_ff @(posedge clk) begin
    if (!rst_n) sync_edge_event <= 1'b0;
    else sync_edge_event <= sync_q[27] && !sync_prev_q;
  end

  logic [7:0] phy_first_q, phy_second_q, acc_ctrl_q, sys_ctrl_q;
  logic       erase_key_q, prog_key_q, urow_key_q;
  logic       prog_status_q, urow_status_q, copying_q;
  logic [63:0] key_shift_q;
  logic [3:0]  key_count_q;
  logic [7:0]  row_buf_q [USER_ROW_BYTES];
  logic [4:0]  copy_idx_q;

  logic is_reg_write, is_key_byte, reset_release, bus_blocked;
  logic key_done;
  logic [63:0] key_full;
  assign is_reg_write  = edge_seen && (cmd == CMD_REG_WRITE);
  assign is_key_byte   = edge_seen && (cmd == CMD_KEY_BYTE);
  assign reset_release = system_reset_active && is_reg_write &&
                         addr[3:0] == OFS_RESET_REQ &&
                         wdata != RESET_SIGNATURE;
  assign key_full      = {wdata, key_shift_q[63:8]};
  assign key_done      = is_key_byte && key_count_q == KEY_BYTES - 4'h1;
  // Sleep with the clock really stopped leaves no bus to reach
  assign bus_blocked   = lock_bits || system_reset_active ||
                         (sys_sleeping && !sys_ctrl_q[BIT_KEEP_CLOCK]);

  // Key bytes collected low byte first, compared after the eighth
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_shift_q <= '0;
      key_count_q <= '0;
    end else if (is_key_byte) begin
      key_shift_q <= key_full;
      key_count_q <= key_done ? 4'h0 : key_count_q + 4'h1;
    end
  end

  // Key-active bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erase_key_q <= 1'b0;
      prog_key_q  <= 1'b0;
      urow_key_q  <= 1'b0;
    end else begin
      if (key_done && key_full == KEY_ERASE) erase_key_q <= 1'b1;
      else if (erase_key_q && erase_done) erase_key_q <= 1'b0;
      if (key_done && key_full == KEY_PROGRAM) prog_key_q <= 1'b1;
      else if (prog_status_q && reset_release) prog_key_q <= 1'b0;
      if (key_done && key_full == KEY_USER_ROW) urow_key_q <= 1'b1;
      else if (is_reg_write && addr[3:0] == OFS_KEY_STATUS &&
               wdata[BIT_USER_ROW_KEY])
        urow_key_q <= 1'b0;
    end
  end

  // Reset request; any value but the signature releases
  always_ff @(posedge clk) begin
    if (!rst_n) system_reset_active <= 1'b0;
    else if (is_reg_write && addr[3:0] == OFS_RESET_REQ)
      system_reset_active <= wdata == RESET_SIGNATURE;
  end

  // Erase starts on reset release with key; detector forced meanwhile
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erase_request  <= 1'b0;
      brownout_force <= 1'b0;
      brownout_level <= '0;
    end else begin
      erase_request <= reset_release && erase_key_q;
      if (reset_release && erase_key_q) brownout_force <= 1'b1;
      else if (erase_done) brownout_force <= 1'b0;
      brownout_level <= bod_fuse_level;
    end
  end

  // Programming modes entered on a reset pulse with the key held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_status_q <= 1'b0;
      urow_status_q <= 1'b0;
    end else if (reset_release) begin
      prog_status_q <= prog_key_q && !prog_status_q && !lock_bits;
      if (urow_key_q && lock_bits) urow_status_q <= 1'b1;
    end else if (copying_q && copy_idx_q == 5'(USER_ROW_BYTES - 1)) begin
      urow_status_q <= 1'b0;
    end
  end

  // Memory access through the link, gated by lock and mode
  logic mem_write_cmd, mem_read_cmd, mem_ok;
  assign mem_write_cmd = edge_seen && cmd == CMD_MEM_WRITE;
  assign mem_read_cmd  = edge_seen && cmd == CMD_MEM_READ;
  always_comb begin
    if (urow_status_q)
      mem_ok = mem_write_cmd && addr < 16'(USER_ROW_BYTES);
    else
      mem_ok = !bus_blocked && (mem_read_cmd ||
               (mem_write_cmd && prog_status_q));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
    end else begin
      mem_we <= mem_ok && mem_write_cmd && !urow_status_q;
      mem_re <= mem_ok && mem_read_cmd;
      if (mem_ok) begin
        mem_addr  <= addr;
        mem_wdata <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (urow_status_q && mem_ok)
      row_buf_q[addr[4:0]] <= wdata;
  end

  // Final write copies buffer into the row, one byte per cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      copying_q  <= 1'b0;
      copy_idx_q <= '0;
      row_we     <= 1'b0;
      row_addr   <= '0;
      row_wdata  <= '0;
    end else begin
      row_we <= copying_q;
      if (copying_q) begin
        row_addr   <= copy_idx_q;
        row_wdata  <= row_buf_q[copy_idx_q];
        copy_idx_q <= copy_idx_q + 5'h1;
        if (copy_idx_q == 5'(USER_ROW_BYTES - 1)) copying_q <= 1'b0;
      end else if (urow_status_q && is_reg_write &&
                   addr[3:0] == OFS_SYS_CTRL && wdata[BIT_FINAL_WRITE]) begin
        copying_q  <= 1'b1;
        copy_idx_q <= '0;
      end
    end
  end

  // Plain read/write registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phy_first_q  <= '0;
      phy_second_q <= '0;
      acc_ctrl_q   <= ACC_CTRL_RESET;
      sys_ctrl_q   <= SYS_CTRL_RESET;
    end else if (is_reg_write) begin
      unique case (addr[3:0])
        OFS_PHY_FIRST:  phy_first_q  <= wdata;
        OFS_PHY_SECOND: phy_second_q <= wdata & 8'h1C;
        OFS_ACC_CTRL:   acc_ctrl_q   <= wdata & 8'h03;
        OFS_SYS_CTRL:   sys_ctrl_q   <= wdata & 8'h01;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_hold           <= 1'b0;
      keep_clock_request <= 1'b1;
    end else begin
      cpu_hold           <= prog_status_q || urow_status_q;
      keep_clock_request <= sys_ctrl_q[BIT_KEEP_CLOCK];
    end
  end

  // Register read mux; link is the only path in
  logic [7:0] reg_rdata;
  always_comb begin
    reg_rdata = 8'h00;
    unique case (addr[3:0])
      OFS_REVISION:   reg_rdata = {REVISION_VALUE, 4'h0};
      OFS_PHY_FIRST:  reg_rdata = phy_first_q;
      OFS_PHY_SECOND: reg_rdata = phy_second_q;
      OFS_KEY_STATUS: begin
        reg_rdata[BIT_USER_ROW_KEY] = urow_key_q;
        reg_rdata[BIT_PROGRAM_KEY]  = prog_key_q;
        reg_rdata[BIT_ERASE_KEY]    = erase_key_q;
      end
      OFS_RESET_REQ:  reg_rdata[0] = system_reset_active;
      OFS_ACC_CTRL:   reg_rdata = acc_ctrl_q;
      OFS_SYS_CTRL:   reg_rdata = sys_ctrl_q;
      OFS_SYS_STATUS: begin
        reg_rdata[BIT_RST_ACTIVE]  = system_reset_active;
        reg_rdata[BIT_SLEEPING]    = sys_sleeping;
        reg_rdata[BIT_PROG_STATUS] = prog_status_q;
        reg_rdata[BIT_UROW_STATUS] = urow_status_q;
        reg_rdata[BIT_LOCK]        = lock_bits;
      end
      OFS_SCAN:       reg_rdata = {5'h00, scan_status};
      default:        reg_rdata = 8'h00;
    endcase
  end

  // Answer: ack, ok and read data all change in one cycle
  logic       answer_pending_q, answer_ok_q;
  logic [7:0] answer_data_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      answer_pending_q <= 1'b0;
      answer_ok_q      <= 1'b0;
      answer_data_q    <= '0;
      link.link_ack    <= 1'b0;
      link.link_ok     <= 1'b0;
      link.link_rdata  <= '0;
    end else begin
      answer_pending_q <= edge_seen && cmd != CMD_SYNC && cmd != CMD_IDLE;
      if (edge_seen) begin
        answer_ok_q <= (cmd == CMD_MEM_WRITE || cmd == CMD_MEM_READ)
                       ? mem_ok : 1'b1;
        answer_data_q <= (cmd == CMD_REG_READ) ? reg_rdata
                                               : link.link_rdata;
      end
      if (answer_pending_q) begin
        link.link_rdata <= mem_re ? mem_rdata : answer_data_q;
        link.link_ok  <= answer_ok_q;
        link.link_ack <= !link.link_ack;
      end
    end
  end
endmodule : debug_access_device

// [debug_access_host.sv]
// Debugger end: drives commands, link clock and sync character
module debug_access_host
  import debug_link_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  debug_link_if.host       link,
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_cmd,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             req_ready,
  output logic             resp_valid,
  output logic             resp_ok,
  output logic [7:0]       resp_rdata
);
  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_HIGH, H_WAIT, H_SYNC
  } host_state_e;
  host_state_e state_q;

  logic [9:0] meta_q, sync_q;
  logic       ack_prev_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q     <= '0;
      sync_q     <= '0;
      ack_prev_q <= 1'b0;
    end else begin
      meta_q     <= {link.link_ack, link.link_ok, link.link_rdata};
      sync_q     <= meta_q;
      ack_prev_q <= sync_q[9];
    end
  end

  // Half-period divider; link clock and sync pattern step on it
  logic [2:0] div_q;
  logic       tick;
  assign tick = div_q == 3'(LINK_HALF_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (!rst_n || state_q == H_IDLE) div_q <= '0;
    else div_q <= tick ? 3'h0 : div_q + 3'h1;
  end

  // Sync character 0x55 low bit first gives four rising edges
  logic [3:0] bit_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q        <= H_IDLE;
      bit_q          <= '0;
      req_ready      <= 1'b0;
      resp_valid     <= 1'b0;
      resp_ok        <= 1'b0;
      resp_rdata     <= '0;
      link.link_clk  <= 1'b0;
      link.link_sync <= 1'b0;
      link.link_cmd  <= CMD_IDLE;
      link.link_addr <= '0;
      link.link_wdata <= '0;
    end else begin
      resp_valid <= 1'b0;
      req_ready  <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          req_ready <= !req_valid;
          if (req_valid && req_ready) begin
            link.link_cmd   <= req_cmd;
            link.link_addr  <= req_addr;
            link.link_wdata <= req_wdata;
            bit_q <= '0;
            state_q <= req_cmd == CMD_SYNC ? H_SYNC : H_SETUP;
          end else begin
            req_ready <= 1'b1;
          end
        end
        H_SETUP: if (tick) begin
          link.link_clk <= 1'b1;
          state_q       <= H_HIGH;
        end
        H_HIGH: if (tick) begin
          link.link_clk <= 1'b0;
          state_q       <= H_WAIT;
        end
        H_WAIT: if (sync_q[9] != ack_prev_q) begin
          resp_valid    <= 1'b1;
          resp_ok       <= sync_q[8];
          resp_rdata    <= sync_q[7:0];
          link.link_cmd <= CMD_IDLE;
          state_q       <= H_IDLE;
        end
        H_SYNC: if (tick) begin
          link.link_sync <= !bit_q[0] && bit_q != 4'h8;
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'h8) begin
            resp_valid    <= 1'b1;
            resp_ok       <= 1'b1;
            link.link_cmd <= CMD_IDLE;
            state_q       <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule : debug_access_host

// [debug_access_host_end.sv]
// No logic here; the debugger end is one module

// [debug_link_checker.sv]
// Assertions on the wires between the two debug link ends
module debug_link_checker
  import debug_link_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        link_clk,
  input wire logic [2:0]  link_cmd,
  input wire logic [15:0] link_addr,
  input wire logic [7:0]  link_wdata,
  input wire logic        link_sync,
  input wire logic [7:0]  link_rdata,
  input wire logic        link_ok,
  input wire logic        link_ack
);
  logic       lclk_q;
  logic       ack_q;
  logic       rst_act_q;
  logic [3:0] since_q;
  logic       go;
  logic       ans;
  logic       rd;
  logic       wr_rst;
  logic [3:0] ofs;
  assign go     = link_clk & ~lclk_q;
  assign ans    = link_ack ^ ack_q;
  assign ofs    = link_addr[3:0];
  assign rd     = go && link_cmd == CMD_REG_READ;
  assign wr_rst = go && link_cmd == CMD_REG_WRITE && ofs == OFS_RESET_REQ;
  always_ff @(posedge clk) begin
    lclk_q <= link_clk;
    ack_q  <= link_ack;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || go) begin
      since_q <= 4'h0;
    end else if (since_q != 4'hF) begin
      since_q <= since_q + 4'h1;
    end
  end
  // Mirror of the reset request, taken from the wire itself
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_act_q <= 1'b0;
    end else if (wr_rst) begin
      rst_act_q <= link_wdata == RESET_SIGNATURE;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_answer_after_frame:
    assert property (ans |-> since_q inside {[1:10]})
    else $error("link answer without a frame");
  a_frame_gets_answer:
    assert property (go && link_cmd inside {CMD_KEY_BYTE, CMD_REG_WRITE,
      CMD_REG_READ, CMD_MEM_WRITE, CMD_MEM_READ} |-> ##[1:10] ans)
    else $error("frame left without answer");
  a_revision_read:
    assert property (rd && ofs == OFS_REVISION |->
      ##[1:10] (ans && link_rdata == 8'h10))
    else $error("revision register read wrong");
  a_reset_req_read:
    assert property (rd && ofs == OFS_RESET_REQ |->
      ##[1:10] (ans && link_rdata == {7'h00, rst_act_q}))
    else $error("reset request read wrong");
  a_sys_reset_bit:
    assert property (rd && ofs == OFS_SYS_STATUS |->
      ##[1:10] (ans && link_rdata[BIT_RST_ACTIVE] == rst_act_q))
    else $error("reset active status bit wrong");
  a_reset_blocks_mem:
    assert property (go && rst_act_q && link_cmd inside {CMD_MEM_WRITE,
      CMD_MEM_READ} |-> ##[1:10] (ans && !link_ok))
    else $error("memory access taken during system reset");
  a_key_status_bits:
    assert property (rd && ofs == OFS_KEY_STATUS |-> ##[1:10]
      (ans && link_rdata[7:6] == 2'b00 && link_rdata[2:0] == 3'b000))
    else $error("key status unused bits set");
  a_answer_stands:
    assert property (!ans |-> $stable(link_rdata) && $stable(link_ok))
    else $error("answer changed without ack");
endmodule : debug_link_checker

// [test_debug_key_access_control.sv]
// Bench driving the debugger end and the system side of the device end
module test_debug_key_access_control import debug_link_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, lock_bits, sys_sleeping, erase_done, ok;
  logic        system_reset_active, erase_request, brownout_force;
  logic        cpu_hold, mem_we, mem_re, row_we, sync_edge_event;
  logic        keep_clock_request, req_valid, req_ready, resp_valid;
  logic        resp_ok, lclk_q, sync_q;
  logic [2:0]  bod_fuse_level, scan_status, brownout_level, req_cmd;
  logic [4:0]  row_addr;
  logic [7:0]  mem_rdata, mem_wdata, row_wdata, req_wdata, resp_rdata;
  logic [7:0]  rd, we_data;
  logic [7:0]  row_mem [32];
  logic [15:0] mem_addr, req_addr, we_addr;
  logic [63:0] wire_key;
  int          err_count, cmp_count, erase_n, row_n, sync_n, edge_n;

  debug_link_if debug_link_if_i ();
  debug_access_device debug_access_device_i (
    .clk, .rst_n, .link(debug_link_if_i), .lock_bits, .sys_sleeping,
    .erase_done, .bod_fuse_level, .scan_status, .mem_rdata,
    .system_reset_active, .erase_request, .brownout_force,
    .brownout_level, .cpu_hold, .mem_we, .mem_re, .mem_addr, .mem_wdata,
    .row_we, .row_addr, .row_wdata, .sync_edge_event, .keep_clock_request);
  debug_access_host debug_access_host_i (
    .clk, .rst_n, .link(debug_link_if_i), .req_valid, .req_cmd,
    .req_addr, .req_wdata, .req_ready, .resp_valid, .resp_ok, .resp_rdata);
  debug_link_checker debug_link_checker_i (
    .clk, .rst_n, .link_clk(debug_link_if_i.link_clk),
    .link_cmd(debug_link_if_i.link_cmd),
    .link_addr(debug_link_if_i.link_addr),
    .link_wdata(debug_link_if_i.link_wdata),
    .link_sync(debug_link_if_i.link_sync),
    .link_rdata(debug_link_if_i.link_rdata),
    .link_ok(debug_link_if_i.link_ok), .link_ack(debug_link_if_i.link_ack));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watches pulses and the key bytes as they cross the wire
  always @(posedge clk) begin
    if (erase_request === 1'b1) erase_n++;
    if (row_we === 1'b1) row_n++;
    if (row_we === 1'b1) row_mem[row_addr] = row_wdata;
    if (sync_edge_event === 1'b1) sync_n++;
    if (debug_link_if_i.link_sync === 1'b1 && sync_q === 1'b0) edge_n++;
    if (mem_we === 1'b1 || mem_re === 1'b1) we_addr = mem_addr;
    if (mem_we === 1'b1) we_data = mem_wdata;
    if (debug_link_if_i.link_clk === 1'b1 && lclk_q === 1'b0 &&
        debug_link_if_i.link_cmd === CMD_KEY_BYTE)
      wire_key = {debug_link_if_i.link_wdata, wire_key[63:8]};
    lclk_q = debug_link_if_i.link_clk;
    sync_q = debug_link_if_i.link_sync;
  end

  task automatic chk(input string what, input logic [63:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      err_count++;
    end
  endtask : chk

  // Request held until taken; answer sampled at its single pulse
  task automatic xfer(input logic [2:0] c, input logic [15:0] a,
                      input logic [7:0] d);
    int n;
    req_cmd   <= c;
    req_addr  <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    n = 0;
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 99);
    req_valid <= 1'b0;
    n = 0;
    do @(posedge clk); while (resp_valid !== 1'b1 && ++n < 99);
    if (n >= 99) chk("response", 1, 0);
    ok = resp_ok;
    rd = resp_rdata;
  endtask : xfer

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(CMD_REG_WRITE, {12'h000, a}, d);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] e,
                     input string what);
    xfer(CMD_REG_READ, {12'h000, a}, 8'h00);
    chk(what, e, rd);
  endtask : rdc

  task automatic mem(input logic [2:0] c, input logic [15:0] a,
                     input logic e, input string what);
    xfer(c, a, 8'h3C);
    chk(what, e, ok);
  endtask : mem

  task automatic key(input logic [63:0] k);
    for (int i = 0; i < 8; i++) begin
      xfer(CMD_KEY_BYTE, 16'h0000, k[i*8 +: 8]);
    end
    chk("key on wire", k, wire_key);
  endtask : key

  task automatic pulse_reset;
    wr(OFS_RESET_REQ, RESET_SIGNATURE);
    wr(OFS_RESET_REQ, 8'h00);
  endtask : pulse_reset

  task automatic t_regs;
    chk("keep clock pin", 1, keep_clock_request);
    rdc(OFS_REVISION, 8'h10, "revision");
    rdc(OFS_ERROR, 8'h00, "error status");
    rdc(OFS_ACC_CTRL, ACC_CTRL_RESET, "access control");
    rdc(OFS_SYS_CTRL, 8'h01, "system control");
    rdc(OFS_SCAN, 8'h05, "scan status");
    rdc(4'h5, 8'h00, "reserved offset");
    wr(OFS_REVISION, 8'hFF);
    rdc(OFS_REVISION, 8'h10, "revision after write");
    wr(OFS_PHY_FIRST, 8'hA5);
    rdc(OFS_PHY_FIRST, 8'hA5, "phy control first");
    wr(OFS_PHY_SECOND, 8'hFF);
    rdc(OFS_PHY_SECOND, 8'h1C, "phy control second");
    chk("idle link clock", 0, debug_link_if_i.link_clk);
  endtask : t_regs

  task automatic t_keys;
    key(KEY_ERASE ^ 64'h0100);
    rdc(OFS_KEY_STATUS, 8'h00, "key status bad key");
    key(KEY_USER_ROW);
    rdc(OFS_KEY_STATUS, 8'h20, "key status row key");
    wr(OFS_KEY_STATUS, 8'h20);
    rdc(OFS_KEY_STATUS, 8'h00, "key status cleared");
  endtask : t_keys

  task automatic t_erase;
    mem(CMD_MEM_READ, 16'h0100, 0, "locked read");
    mem(CMD_MEM_WRITE, 16'h0100, 0, "locked write");
    rdc(OFS_SYS_STATUS, 8'h01, "status locked");
    key(KEY_ERASE);
    rdc(OFS_KEY_STATUS, 8'h08, "erase key status");
    wr(OFS_RESET_REQ, RESET_SIGNATURE);
    chk("system reset set", 1, system_reset_active);
    rdc(OFS_RESET_REQ, 8'h01, "reset request read");
    wr(OFS_RESET_REQ, 8'h00);
    chk("system reset clear", 0, system_reset_active);
    chk("erase requests", 1, erase_n);
    chk("brownout forced", 1, brownout_force);
    chk("brownout level", 3'h6, brownout_level);
    @(posedge clk);
    erase_done <= 1'b1;
    lock_bits  <= 1'b0;
    @(posedge clk);
    erase_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk("brownout released", 0, brownout_force);
    rdc(OFS_SYS_STATUS, 8'h00, "status unlocked");
    rdc(OFS_KEY_STATUS, 8'h00, "erase key cleared");
  endtask : t_erase

  task automatic t_prog;
    mem(CMD_MEM_WRITE, 16'h1234, 0, "write outside prog");
    key(KEY_PROGRAM);
    wr(OFS_RESET_REQ, RESET_SIGNATURE);
    mem(CMD_MEM_READ, 16'h1234, 0, "read in reset");
    wr(OFS_RESET_REQ, 8'h00);
    rdc(OFS_SYS_STATUS, 8'h08, "status prog");
    chk("cpu hold", 1, cpu_hold);
    mem(CMD_MEM_WRITE, 16'h1234, 1, "prog write");
    chk("written address", 16'h1234, we_addr);
    chk("written data", 8'h3C, we_data);
    mem(CMD_MEM_READ, 16'h1235, 1, "prog read");
    chk("read data", 8'h96, rd);
    chk("read address", 16'h1235, we_addr);
    pulse_reset;
    rdc(OFS_SYS_STATUS, 8'h00, "status prog done");
    rdc(OFS_KEY_STATUS, 8'h00, "prog key cleared");
  endtask : t_prog

  task automatic t_row;
    lock_bits <= 1'b1;
    key(KEY_USER_ROW);
    pulse_reset;
    rdc(OFS_SYS_STATUS, 8'h05, "status row");
    mem(CMD_MEM_WRITE, 16'h001F, 1, "row last byte");
    mem(CMD_MEM_WRITE, 16'h0020, 0, "row outside");
    mem(CMD_MEM_READ, 16'h0003, 0, "row read");
    row_n = 0;
    wr(OFS_SYS_CTRL, 8'h03);
    // 32 copies start two cycles after the final write lands
    repeat (40) @(posedge clk);
    chk("row copies", 32, row_n);
    chk("row byte 31", 8'h3C, row_mem[31]);
    rdc(OFS_SYS_STATUS, 8'h01, "status row done");
    rdc(OFS_SYS_CTRL, 8'h01, "final bit reads 0");
    wr(OFS_KEY_STATUS, 8'h20);
    pulse_reset;
  endtask : t_row

  task automatic t_sleep;
    lock_bits    <= 1'b0;
    sys_sleeping <= 1'b1;
    rdc(OFS_SYS_STATUS, 8'h10, "status sleeping");
    mem(CMD_MEM_READ, 16'h0040, 1, "read clock kept");
    wr(OFS_SYS_CTRL, 8'h00);
    chk("keep clock off", 0, keep_clock_request);
    mem(CMD_MEM_READ, 16'h0040, 0, "read clock off");
    wr(OFS_SYS_CTRL, 8'h01);
    sys_sleeping <= 1'b0;
  endtask : t_sleep

  task automatic t_sync;
    sync_n = 0;
    edge_n = 0;
    xfer(CMD_SYNC, 16'h0000, 8'h00);
    repeat (6) @(posedge clk);
    chk("sync events", edge_n, sync_n);
    chk("sync edges seen", 4, edge_n);
  endtask : t_sync

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    rst_n          = 1'b0;
    lock_bits      = 1'b1;
    sys_sleeping   = 1'b0;
    erase_done     = 1'b0;
    bod_fuse_level = 3'h6;
    scan_status    = 3'h5;
    mem_rdata      = 8'h96;
    req_valid      = 1'b0;
    req_cmd        = 3'h0;
    req_addr       = 16'h0000;
    req_wdata      = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs;
    t_keys;
    t_erase;
    t_prog;
    t_row;
    t_sleep;
    t_sync;
    stop_test;
  end

  // Whole sequence needs well under 20000 cycles
  initial begin
    #2000000;
    err_count++;
    stop_test;
  end
endmodule : test_debug_key_access_control
